//--- dbmh_map.svh
/*
  Timing and address constants for the DMA bus mastership block.
  Assumes a 20 MHz local clock; every delay count is derived from a time in ns.
*/
//------------------------------------------------------------
// Contract
// - Hold bus request until mastership is taken.
// - Pass grant onward unless this block requests.
// - Requesting block blocks grant, asserts acknowledge.
// - Wait sync and reply idle, acknowledge, drop request.
// - First sync at least 250 ns after grant.
// - Keep acknowledge for the whole transfer phase.
// - At most four words per tenure.
// - Release after last reply negates, drop acknowledge, sync.
// - Acknowledge may lead sync by 300 ns at most; here the first sync comes 500 ns after acknowledge.
// - Wait 4 us before requesting, unless work pending; here only a command new since release cuts it short.
// - Read: address, sync, remove address, read strobe.
// - Assert I/O page select for top 4K words.
// - Write half: data, byte flag, write strobe, then release.
//------------------------------------------------------------
`ifndef DBMH_MAP_SVH
`define DBMH_MAP_SVH
`define DBMH_CLK_NS 50
`define DBMH_CYC(ns) (((ns) + `DBMH_CLK_NS - 1) / `DBMH_CLK_NS)
`define DBMH_SETTLE_NS 250
`define DBMH_ADDR_SETUP_NS 75
`define DBMH_ADDR_HOLD_NS 25
`define DBMH_DIN_DELAY_NS 100
`define DBMH_DESKEW_NS 200
`define DBMH_DOUT_HOLD_NS 150
`define DBMH_SYNC_TAIL_NS 200
`define DBMH_GAP_NS 300
`define DBMH_HOLDOFF_NS 4000
`define DBMH_MAX_WORDS 3'h4
`define DBMH_IO_PAGE_BASE 18'h3E000
`define DBMH_FIFO_DEPTH 2'h2
`endif

//--- dbmh_pkg.sv
/*
  Types shared by the DMA bus mastership block.
  Assumes dbmh_map.svh supplies the numeric constants.
*/
package dbmh_pkg;
  // Bus cycle kinds that a command may ask for.
  typedef enum logic [1:0] {DBMH_READ, DBMH_WRITE, DBMH_RMW} dbmh_op_type;
  // Sequencer states.
  typedef enum logic [4:0] {S_IDLE, S_REQ, S_WBUS, S_SETTLE, S_TAKE, S_ADDR, S_SYNC, S_PRE, S_DIN,
    S_DINOFF, S_DATA, S_DOUT, S_DOUTOFF, S_ENDC, S_GAP, S_REL, S_HOLD} dbmh_state_type;
endpackage : dbmh_pkg

//--- dbmh_master.sv
/*
  DMA bus master: acquires the backplane bus over the grant daisy chain, runs up to four
  read, write or read-modify-write cycles, releases the bus and backs off.
  Assumes bus pins are active-high levels here (pad inversion outside), and that the
  command source holds cmd_valid and its fields until cmd_ready.
*/
`timescale 1ns/100ps
`include "dbmh_map.svh"
module dbmh_master
  import dbmh_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire dbmh_op_type cmd_op,
  input wire logic cmd_byte,
  input wire logic [17:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [15:0] rd_data,
  output logic dma_bus_request,
  input wire logic grant_chain_in,
  output logic grant_chain_out,
  output logic mastership_acknowledge,
  input wire logic cycle_sync_in,
  output logic cycle_sync_strobe,
  input wire logic slave_reply,
  output logic read_strobe,
  output logic write_strobe,
  output logic io_page_select,
  output logic write_byte_flag,
  input wire logic [15:0] mad_in,
  output logic [15:0] mad_out,
  output logic mad_oe
);
  //------------------------------------------------------------
  // Input synchronisers
  //------------------------------------------------------------
  logic [2:0] sync1; // First stage, read only by sync2.
  logic [2:0] sync2; // Grant, sync and reply on the local clock.
  wire g_s = sync2[2];
  wire sy_s = sync2[1];
  wire rp_s = sync2[0];
  // Two flops each for grant, sync and reply; the bus has no shared clock.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {grant_chain_in, cycle_sync_in, slave_reply};
      sync2 <= sync1;
    end
  end
  //------------------------------------------------------------
  // Read data buffer
  //------------------------------------------------------------
  logic [15:0] mem [0:1]; // Two entries so a stalled reader loses nothing.
  logic wp; // Write index.
  logic rp; // Read index.
  logic [1:0] cnt; // Occupancy.
  logic push; // Captured read word, a one-cycle strobe.
  wire room = cnt != `DBMH_FIFO_DEPTH;
  wire pop = rd_valid && rd_ready;
  wire [1:0] next_cnt = cnt + {1'b0, push} - {1'b0, pop};
  // Reads are only started with room, so push never meets a full buffer.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'h0;
    end else begin
      wp <= wp ^ push;
      rp <= rp ^ pop;
      cnt <= next_cnt;
    end
  end
  // Storage has no reset; it is never read while empty.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp] <= mad_in;
    end
  end
  // Output side is registered from the next occupancy and index.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data <= 16'h0000;
    end else begin
      rd_valid <= next_cnt != 2'h0;
      rd_data <= (cnt == 2'h0 || (pop && cnt == 2'h1)) ? mad_in : mem[rp ^ pop];
    end
  end
  //------------------------------------------------------------
  // Sequencer
  //------------------------------------------------------------
  dbmh_state_type state; // Present state.
  dbmh_state_type next_state; // Following state.
  logic [6:0] timer; // Down counter for every minimum delay.
  logic [6:0] next_timer;
  logic [2:0] words; // Words moved this tenure.
  dbmh_op_type op; // Latched command.
  logic byte_w;
  logic [17:0] addr;
  logic [15:0] wdata;
  logic seen; // Command was already waiting at release.
  wire t0 = timer == 7'h00;
  wire can_go = cmd_valid && (room || cmd_op == DBMH_WRITE);
  wire more = words < `DBMH_MAX_WORDS && can_go;
  // Next state; every timed wait counts local clock cycles.
  always_comb begin
    next_state = state;
    next_timer = t0 ? timer : timer - 7'h01;
    push = 1'b0;
    unique case (state)
      S_IDLE: if (can_go) next_state = S_REQ;
      S_REQ: if (g_s) next_state = S_WBUS; // Request held through grant until acknowledge.
      S_WBUS: begin
        if (!sy_s && !rp_s) begin // Bus idle before acknowledge.
          next_state = S_SETTLE;
          next_timer = 7'(`DBMH_CYC(`DBMH_SETTLE_NS));
        end
      end
      S_SETTLE: if (t0) next_state = S_TAKE;
      S_TAKE: begin
        next_state = S_ADDR;
        next_timer = 7'(`DBMH_CYC(`DBMH_ADDR_SETUP_NS));
      end
      S_ADDR: begin
        if (t0) begin
          next_state = S_SYNC;
          next_timer = 7'(`DBMH_CYC(`DBMH_ADDR_HOLD_NS));
        end
      end
      S_SYNC: begin
        if (t0) begin
          next_state = (op == DBMH_WRITE) ? S_DATA : S_PRE; // Address removed.
          next_timer = 7'(`DBMH_CYC(`DBMH_DIN_DELAY_NS));
        end
      end
      S_PRE: begin
        if (t0) begin
          next_state = S_DIN;
          next_timer = 7'(`DBMH_CYC(`DBMH_DESKEW_NS));
        end
      end
      S_DIN: begin
        if (!rp_s) begin
          next_timer = timer; // Deskew counts only once the reply is seen.
        end else if (t0) begin
          push = 1'b1; // Take the data, then drop the read strobe.
          next_state = S_DINOFF;
        end
      end
      S_DINOFF: begin
        if (!rp_s) begin
          next_state = (op == DBMH_RMW) ? S_DATA : S_ENDC;
          next_timer = 7'(`DBMH_CYC(`DBMH_DESKEW_NS));
        end
      end
      S_DATA: begin
        if (t0) begin
          next_state = S_DOUT;
          next_timer = 7'(`DBMH_CYC(`DBMH_DOUT_HOLD_NS));
        end
      end
      S_DOUT: begin
        if (!rp_s) begin
          next_timer = timer;
        end else if (t0) begin
          next_state = S_DOUTOFF;
          next_timer = 7'(`DBMH_CYC(`DBMH_SYNC_TAIL_NS));
        end
      end
      S_DOUTOFF: if (t0 && !rp_s) next_state = S_ENDC;
      S_ENDC: begin
        next_state = S_GAP;
        next_timer = 7'(`DBMH_CYC(`DBMH_GAP_NS));
      end
      S_GAP: if (t0) next_state = more ? S_TAKE : S_REL;
      S_REL: begin
        next_state = S_HOLD;
        next_timer = 7'(`DBMH_CYC(`DBMH_HOLDOFF_NS));
      end
      S_HOLD: if (t0 || (can_go && !seen)) next_state = S_IDLE;
    endcase
  end
  // Decoded output levels for the coming state.
  wire n_ack = next_state inside {[S_SETTLE:S_GAP]}; // Whole transfer phase.
  wire n_sync = next_state inside {[S_SYNC:S_DOUTOFF]};
  wire n_drive_a = next_state inside {S_ADDR, S_SYNC};
  wire n_drive_d = next_state inside {S_DATA, S_DOUT, S_DOUTOFF};
  wire n_want = next_state inside {[S_REQ:S_REL]};
  wire next_io = addr >= `DBMH_IO_PAGE_BASE;
  // Latch the command and tenure bookkeeping.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      timer <= 7'h00;
      words <= 3'h0;
      op <= DBMH_READ;
      byte_w <= 1'b0;
      addr <= 18'h00000;
      wdata <= 16'h0000;
      seen <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      seen <= (state == S_REL) ? cmd_valid : seen;
      words <= (state == S_REL) ? 3'h0 : words + {2'h0, state == S_ENDC};
      if (state == S_TAKE) begin
        op <= cmd_op;
        byte_w <= cmd_byte;
        addr <= cmd_addr;
        wdata <= cmd_wdata;
      end
    end
  end
  // Every pin output is a flop driven from the coming state.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_ready <= 1'b0;
      dma_bus_request <= 1'b0;
      grant_chain_out <= 1'b0;
      mastership_acknowledge <= 1'b0;
      cycle_sync_strobe <= 1'b0;
      read_strobe <= 1'b0;
      write_strobe <= 1'b0;
      io_page_select <= 1'b0;
      write_byte_flag <= 1'b0;
      mad_out <= 16'h0000;
      mad_oe <= 1'b0;
    end else begin
      cmd_ready <= next_state == S_TAKE;
      dma_bus_request <= next_state inside {S_REQ, S_WBUS}; // Dropped with acknowledge.
      grant_chain_out <= g_s && !n_want; // Pass or block the grant.
      mastership_acknowledge <= n_ack; // Falls with or after sync.
      cycle_sync_strobe <= n_sync;
      read_strobe <= next_state == S_DIN;
      write_strobe <= next_state == S_DOUT;
      io_page_select <= n_drive_a && next_io;
      write_byte_flag <= (n_drive_a && op == DBMH_WRITE) || (n_drive_d && byte_w);
      mad_out <= n_drive_a ? addr[15:0] : wdata;
      mad_oe <= n_drive_a || n_drive_d;
    end
  end
  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  logic [3:0] since_ack; // Cycles since acknowledge rose, saturating.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) since_ack <= 4'h0;
    else since_ack <= !mastership_acknowledge ? 4'h0 : (since_ack == 4'hF ? since_ack : since_ack + 4'h1);
  end
  property p_req_hold;
    @(posedge mclk) disable iff (rst) $fell(dma_bus_request) |-> mastership_acknowledge;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped without mastership");
  property p_grant_pass;
    @(posedge mclk) disable iff (rst) grant_chain_out |-> $past(g_s) && !mastership_acknowledge;
  endproperty
  a_grant_pass: assert property (p_grant_pass) else $error("grant passed wrongly");
  property p_grant_block;
    @(posedge mclk) disable iff (rst) (dma_bus_request && g_s) |=> !grant_chain_out;
  endproperty
  a_grant_block: assert property (p_grant_block) else $error("grant not blocked");
  property p_ack_idle;
    @(posedge mclk) disable iff (rst) $rose(mastership_acknowledge) |-> !$past(sy_s) && !$past(rp_s);
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("acknowledge on a busy bus");
  property p_settle;
    @(posedge mclk) disable iff (rst) $rose(cycle_sync_strobe) |-> since_ack >= 4'(`DBMH_CYC(`DBMH_SETTLE_NS));
  endproperty
  a_settle: assert property (p_settle) else $error("sync too soon after grant");
  property p_ack_cover;
    @(posedge mclk) disable iff (rst) (cycle_sync_strobe || read_strobe || write_strobe) |-> mastership_acknowledge;
  endproperty
  a_ack_cover: assert property (p_ack_cover) else $error("transfer without mastership");
  property p_words;
    @(posedge mclk) disable iff (rst) words <= `DBMH_MAX_WORDS;
  endproperty
  a_words: assert property (p_words) else $error("too many words in one tenure");
  property p_release;
    @(posedge mclk) disable iff (rst) $fell(mastership_acknowledge) |-> !cycle_sync_strobe && !$past(rp_s);
  endproperty
  a_release: assert property (p_release) else $error("early release");
  property p_read;
    @(posedge mclk) disable iff (rst) $rose(read_strobe) |-> cycle_sync_strobe && !mad_oe;
  endproperty
  a_read: assert property (p_read) else $error("read strobe with address on bus");
  property p_write_end;
    @(posedge mclk) disable iff (rst) $fell(write_strobe) |-> cycle_sync_strobe [*4];
  endproperty
  a_write_end: assert property (p_write_end) else $error("sync dropped too soon after write");
  c_read: cover property (@(posedge mclk) disable iff (rst) $fell(read_strobe));
  c_write: cover property (@(posedge mclk) disable iff (rst) $fell(write_strobe) && !$past(read_strobe, 20));
  c_four: cover property (@(posedge mclk) disable iff (rst) words == `DBMH_MAX_WORDS);
endmodule : dbmh_master

//--- dbmh_bus_model.sv
/*
  Behavioural far side of the DMA master: the processor that arbitrates and grants the bus,
  and one memory slave of 256 words. Assumes active-high bus levels on the 20 MHz clock.
*/
`timescale 1ns/100ps
module dbmh_bus_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic dma_bus_request,
  input wire logic mastership_acknowledge,
  input wire logic cycle_sync_strobe,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic write_byte_flag,
  input wire logic [15:0] mad_out,
  input wire logic mad_oe,
  input wire logic spurious,
  input wire logic slow,
  output logic grant_chain_in,
  output logic slave_reply,
  output logic cycle_sync_in,
  output logic [15:0] mad_in
);
  // ----------------------------------------
  // Processor arbiter and memory slave
  // ----------------------------------------
  logic cpu_sync; // The processor's own sync strobe.
  logic sync_q; // Sync seen at the previous edge.
  logic a0; // Latched byte select.
  logic [4:0] cnt; // Arbitration timer.
  logic [3:0] dly; // Reply delay; slow mode stretches it.
  logic [7:0] sel; // Latched word select.
  logic [15:0] drv; // Slave data; inverted once released so stale data never looks valid.
  logic [15:0] mem [256] = '{default: 16'h0000}; // Memory contents, zero at start.
  assign cycle_sync_in = cycle_sync_strobe | cpu_sync;
  assign mad_in = mad_oe ? mad_out : drv;
  // One behavioural process; not meant for synthesis.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      grant_chain_in <= 1'b0;
      cpu_sync <= 1'b0;
      cnt <= 5'h00;
      slave_reply <= 1'b0;
      drv <= 16'h0000;
      sync_q <= 1'b0;
      dly <= 4'h0;
    end else begin
      sync_q <= cycle_sync_strobe;
      if (mastership_acknowledge) begin // Grant taken: drop it, keep own sync off.
        grant_chain_in <= 1'b0;
        cpu_sync <= 1'b0;
        cnt <= 5'h00;
      end else if (grant_chain_in) begin // An unanswered grant is withdrawn.
        cnt <= cnt + 5'h01;
        cpu_sync <= cpu_sync & (cnt < 5'h02);
        if (cnt == 5'h1F) grant_chain_in <= 1'b0;
      end else if (dma_bus_request | spurious) begin // Own sync held on, then grant; own sync ends after the grant.
        cnt <= (cnt == 5'h04) ? 5'h00 : cnt + 5'h01;
        cpu_sync <= 1'b1;
        grant_chain_in <= (cnt == 5'h04);
      end else begin
        cnt <= 5'h00;
        cpu_sync <= 1'b0;
      end
      if (cycle_sync_strobe & ~sync_q) begin // Selection latched at address decode.
        sel <= mad_out[8:1];
        a0 <= mad_out[0];
      end
      if ((read_strobe | write_strobe) & ~slave_reply) begin
        dly <= dly + 4'h1;
        if (dly >= (slow ? 4'h9 : 4'h1)) begin // Data out or in, then reply.
          slave_reply <= 1'b1;
          dly <= 4'h0;
          if (read_strobe) drv <= mem[sel];
          if (write_strobe) mem[sel] <= ~write_byte_flag ? mad_out :
            a0 ? {mad_out[15:8], mem[sel][7:0]} : {mem[sel][15:8], mad_out[7:0]};
        end
      end else if (~read_strobe & ~write_strobe & slave_reply) begin // Strobe gone: release.
        slave_reply <= 1'b0;
        drv <= ~drv;
      end
    end
  end
endmodule : dbmh_bus_model

//--- tb_top.sv
/*
  Self-checking bench for the DMA bus master: directed corners, then seeded random commands.
  Assumes the behavioural bus model and the design's own assertions beside it.
*/
`timescale 1ns/100ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
  import dbmh_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready, rd_valid, dma_bus_request, grant_chain_in, grant_chain_out;
  logic rd_ready = 1'b0; // Reader side of the read buffer, driven by the monitor only.
  logic mastership_acknowledge, cycle_sync_in, cycle_sync_strobe, slave_reply, read_strobe;
  logic write_strobe, io_page_select, write_byte_flag, mad_oe;
  dbmh_op_type cmd_op = DBMH_READ;
  logic cmd_byte = 1'b0;
  logic [17:0] cmd_addr = 18'h00000;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [15:0] rd_data, mad_in, mad_out;
  logic spurious = 1'b0;
  logic slow = 1'b0;
  logic hold = 1'b0; // Holds the reader off so the read buffer fills.
  logic sync_q = 1'b0;
  logic ack_q = 1'b0;
  logic req_q = 1'b0;
  logic [7:0] words = 8'h00;
  logic [15:0] shadow [256] = '{default: 16'h0000}; // Expected memory, zero like the model.
  logic [15:0] exp_rd = 16'h0000; // Expected head word, popped once per compare.
  logic exp_io = 1'b0; // Expected page select, popped once per compare.
  logic valid_at_rel = 1'b0; // A command was already waiting at the last release.
  int rel_cnt = 0; // Cycles since the last release.
  logic [15:0] expq [$];
  logic [17:0] aq [$];
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int gcnt = 0;
  always #25 mclk = ~mclk;
  dbmh_master u_dut (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_byte(cmd_byte), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .dma_bus_request(dma_bus_request),
    .grant_chain_in(grant_chain_in), .grant_chain_out(grant_chain_out),
    .mastership_acknowledge(mastership_acknowledge), .cycle_sync_in(cycle_sync_in),
    .cycle_sync_strobe(cycle_sync_strobe), .slave_reply(slave_reply), .read_strobe(read_strobe),
    .write_strobe(write_strobe), .io_page_select(io_page_select), .write_byte_flag(write_byte_flag),
    .mad_in(mad_in), .mad_out(mad_out), .mad_oe(mad_oe));
  dbmh_bus_model u_bus (.mclk(mclk), .rst(rst), .dma_bus_request(dma_bus_request),
    .mastership_acknowledge(mastership_acknowledge), .cycle_sync_strobe(cycle_sync_strobe),
    .read_strobe(read_strobe), .write_strobe(write_strobe), .write_byte_flag(write_byte_flag),
    .mad_out(mad_out), .mad_oe(mad_oe), .spurious(spurious), .slow(slow),
    .grant_chain_in(grant_chain_in), .slave_reply(slave_reply), .cycle_sync_in(cycle_sync_in),
    .mad_in(mad_in));
  // ----------------------------------------
  // Expectations and verdict
  // ----------------------------------------
  // A byte write touches only the lane picked by address bit 0.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
    input logic b, input logic a0);
    return ~b ? d : a0 ? {d[15:8], old[7:0]} : {old[15:8], d[7:0]};
  endfunction : merge
  task automatic final_report;
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // Offers one command and holds it until taken, then lets one more edge pass itself.
  task automatic send(input dbmh_op_type op, input logic [17:0] a, input logic [15:0] d, input logic b);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_byte <= b;
    cmd_valid <= 1'b1;
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    @(posedge mclk);
  endtask : send
  // ----------------------------------------
  // Monitors; they sample values from before each edge
  // ----------------------------------------
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      final_report();
    end
    rd_ready <= ~hold & ($urandom_range(3) != 0);
    if (!rst) begin
      if (cmd_valid & cmd_ready) begin
        aq.push_back(cmd_addr);
        if (cmd_op != DBMH_WRITE) expq.push_back(shadow[cmd_addr[8:1]]);
        if (cmd_op != DBMH_READ) shadow[cmd_addr[8:1]] = merge(shadow[cmd_addr[8:1]], cmd_wdata,
          cmd_byte, cmd_addr[0]);
      end
      if (rd_valid & rd_ready) begin
        exp_rd = expq.pop_front();
        `CHK(rd_data, exp_rd)
      end
      if (cycle_sync_strobe & ~sync_q) begin
        words++;
        exp_io = aq.pop_front() >= 18'h3E000;
        `CHK(mastership_acknowledge, 1'b1)
        `CHK(io_page_select, exp_io)
      end
      if (mastership_acknowledge & ~ack_q) begin
        `CHK(dma_bus_request, 1'b0)
        `CHK(grant_chain_out, 1'b0)
      end
      rel_cnt++;
      if (~mastership_acknowledge & ack_q) begin
        `CHK(slave_reply, 1'b0)
        `CHK(words <= 8'h04, 1'b1)
        words = 8'h00;
        rel_cnt = 0; // The holdoff runs from the release.
        valid_at_rel = cmd_valid; // Only a command new since release may cut it short.
      end
      if (~dma_bus_request & req_q) `CHK(mastership_acknowledge, 1'b1)
      // Four microseconds at 50 ns a cycle is 80 cycles.
      if (dma_bus_request & ~req_q) `CHK(rel_cnt >= 80 || !valid_at_rel, 1'b1)
      gcnt = (grant_chain_in & ~dma_bus_request & ~cmd_valid & ~mastership_acknowledge) ? gcnt + 1 : 0;
      if (gcnt == 4) `CHK(grant_chain_out, 1'b1)
    end
    sync_q = cycle_sync_strobe;
    ack_q = mastership_acknowledge;
    req_q = dma_bus_request;
  end
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    void'($urandom(32));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    // Corners: I/O page word, odd byte read-modify-write, full read buffer, a fifth word.
    hold <= 1'b1;
    send(DBMH_WRITE, 18'h3E010, 16'hA5A5, 1'b0);
    send(DBMH_READ, 18'h3E010, 16'h0000, 1'b0);
    send(DBMH_RMW, 18'h00031, 16'h1234, 1'b1);
    // The buffer is full here, so this read waits until the reader is let go.
    fork
      send(DBMH_READ, 18'h00030, 16'h0000, 1'b0);
      begin
        repeat (200) @(posedge mclk);
        hold <= 1'b0;
      end
    join
    for (int i = 0; i < 5; i++) begin
      send(DBMH_WRITE, 18'h00040 + 18'(2 * i), 16'(i), 1'b0);
    end
    // Random traffic; some long gaps let the bus go back and the holdoff run.
    for (int i = 0; i < 48; i++) begin
      slow <= ($urandom_range(3) == 0);
      send(dbmh_op_type'($urandom_range(2)), {$urandom_range(1) ? 5'h1F : 5'h00, 4'h0,
        8'($urandom), 1'($urandom)}, 16'($urandom), 1'($urandom));
      repeat ((i % 8 == 7) ? 120 : $urandom_range(3)) @(posedge mclk);
    end
    // A grant meant for someone else must pass through.
    repeat (200) @(posedge mclk);
    spurious <= 1'b1;
    repeat (12) @(posedge mclk);
    spurious <= 1'b0;
    for (int i = 0; i < 3000 && expq.size() != 0; i++) @(posedge mclk);
    repeat (60) @(posedge mclk);
    final_report();
  end
endmodule : tb_top
